// ==== bench/bkreg_bank_tb_top.sv ====
// self-checking bench for the buck regulator register bank
`timescale 1ns/1ps
`default_nettype none
module bkreg_bank_tb_top;
    logic        clk, rstn, pin, wr_en, hit;
    logic        a_run, b_run, a_pwm, b_pwm, a_dis, b_dis, a_lv, b_lv, a_vv, b_vv;
    logic [7:0]  addr, wdata, rdata;
    logic [2:0]  a_lim, b_lim, a_rmp, b_rmp;
    logic [15:0] a_mv, b_mv;
    logic [7:0]  vc [7] = '{8'h13, 8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};
    int          error_cnt, checked;
    int          m [16];
    int unsigned s = 32'hE917B999;
    bkreg_host host (.i_clk(clk), .o_wr_en(wr_en), .o_addr(addr), .o_wdata(wdata));
    bkreg_bank uut (.i_clk(clk), .i_rstn(rstn), .i_wr_en(wr_en), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .o_addr_hit(hit), .i_en_pin(pin),
        .o_a_run(a_run), .o_b_run(b_run), .o_a_pwm_forced(a_pwm), .o_b_pwm_forced(b_pwm),
        .o_a_discharge(a_dis), .o_b_discharge(b_dis), .o_a_current_limit(a_lim),
        .o_b_current_limit(b_lim), .o_a_limit_valid(a_lv), .o_b_limit_valid(b_lv),
        .o_a_ramp_rate(a_rmp), .o_b_ramp_rate(b_rmp), .o_a_millivolts(a_mv),
        .o_b_millivolts(b_mv), .o_a_voltage_valid(a_vv), .o_b_voltage_valid(b_vv));
    // --------------------------------
    // helpers
    // --------------------------------
    function automatic int unsigned xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic int mv(input int c);
        if (c < 8'h14) return 0;
        if (c < 8'h18) return 700 + 10 * (c - 8'h14);
        if (c < 8'h9E) return 735 + 5 * (c - 8'h18);
        return 1420 + 20 * (c - 8'h9E);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input int a, input int d);
        int v;
        v = d & 8'hFF;
        // the bench never programs ramp codes 0 or 1
        if ((a == 3 || a == 5) && v[2:0] < 3'h2) v = v | 8'h02;
        host.write(a[7:0], v[7:0]);
        if (a >= 3 && a <= 7) m[a] = v;
    endtask
    task automatic check_all();
        logic on;
        on = m[4][0] && (!m[4][1] || pin);
        check(a_run, pin);
        check(a_dis, !pin);
        check(a_pwm, 1'b1);
        check(b_pwm, m[4][3]);
        check(b_run, on);
        check(b_dis, m[4][2] && !on);
        check(a_lim, m[3][5:3]);
        check(b_lim, m[5][5:3]);
        check(a_lv, m[3][5:3] <= 5);
        check(b_lv, m[5][5:3] <= 5);
        check(a_rmp, m[3][2:0]);
        check(b_rmp, m[5][2:0]);
        check(a_mv, 16'(mv(m[6])));
        check(b_mv, 16'(mv(m[7])));
        check(a_vv, m[6] >= 8'h14);
        check(b_vv, m[7] >= 8'h14);
        for (int r = 0; r < 16; r++)
        begin
            host.point(r[7:0]);
            #1;
            check(rdata, m[r][7:0]);
            check(hit, r >= 3 && r <= 7);
        end
    endtask
    task automatic do_reset();
        rstn = 1'b0;
        foreach (m[i]) m[i] = 0;
        m[3] = 8'h2C;
        m[4] = 8'h0F;
        m[5] = 8'h2C;
        m[6] = 8'h80;
        m[7] = 8'hFC;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (5) @(negedge clk);  // let the pin synchroniser settle
        check_all();
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // --------------------------------
    // stimulus
    // --------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #1_200_000;
        error_cnt++;
        final_report();
    end
    initial
    begin
        error_cnt = 0;
        checked = 0;
        pin = 1'b1;
        do_reset();
        $display("test reset done");
        for (int c = 0; c < 8; c++)
        begin
            wr(3, (c << 3) | (7 - c));  // codes change while b runs
            wr(5, (c << 3) | c | 8'hC0);
            check_all();
        end
        $display("test limit and ramp done");
        for (int i = 0; i < 7; i++)
        begin
            wr(6, vc[i]);
            wr(7, vc[6 - i]);
            check_all();
        end
        $display("test voltage done");
        for (int k = 0; k < 32; k++)
        begin
            pin = k[4];
            wr(4, k * 8'h11);
            repeat (5) @(negedge clk);
            check_all();
        end
        $display("test enable done");
        for (int n = 0; n < 150; n++)
        begin
            wr(xs() % 16, xs());
            check_all();
        end
        $display("test random done");
        do_reset();
        $display("test second reset done");
        final_report();
    end
endmodule // bkreg_bank_tb_top
`default_nettype wire

// ==== bench/bkreg_host.sv ====
// host model driving the register bank's write and address port
`timescale 1ns/1ps
`default_nettype none
module bkreg_host (
    input  wire logic       i_clk,
    output logic            o_wr_en,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata
);
    initial
    begin
        o_wr_en = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    // one-cycle strobe; the bench picks which codes go out
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_wr_en = 1'b1;
        o_addr  = a;
        o_wdata = d;
        @(negedge i_clk);
        o_wr_en = 1'b0;
        o_wdata = ~d;  // stale data never looks like the last value
    endtask
    // reads are combinational, so only the address moves
    task automatic point(input logic [7:0] a);
        @(negedge i_clk);
        o_addr = a;
    endtask
endmodule // bkreg_host
`default_nettype wire

// ==== rtl/bkreg_bank.sv ====
// register bank for the two buck regulators with decoded analog controls
// ---------------------------------------------------------------
// Overview of operation
// - limit field bits 5:3, 1.5-4.0 A
// - limit codes 6,7 reserved, flagged invalid
// - limit changes apply while running
// - ramp field bits 2:0, both directions
// - bit 3 forces PWM, resets 1
// - bit 2 discharge when disabled, resets 1
// - bit 1 adds enable pin, resets 1
// - bit 0 enables regulator, resets 1
// - voltage codes below 0x14 reserved
// - 0x14-0x17 give 10 mV steps
// - 0x18-0x9D give 5 mV steps
// - 0x9E-0xFF give 20 mV steps
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bkreg_bank (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_wr_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    output logic             o_addr_hit,
    input  wire logic        i_en_pin,
    output logic             o_a_run,
    output logic             o_b_run,
    output logic             o_a_pwm_forced,
    output logic             o_b_pwm_forced,
    output logic             o_a_discharge,
    output logic             o_b_discharge,
    output logic      [2:0]  o_a_current_limit,
    output logic      [2:0]  o_b_current_limit,
    output logic             o_a_limit_valid,
    output logic             o_b_limit_valid,
    output logic      [2:0]  o_a_ramp_rate,
    output logic      [2:0]  o_b_ramp_rate,
    output logic      [15:0] o_a_millivolts,
    output logic      [15:0] o_b_millivolts,
    output logic             o_a_voltage_valid,
    output logic             o_b_voltage_valid
);
    // ---------------------------------------------------------------
    // code to millivolts
    // ---------------------------------------------------------------
    function automatic logic [16:0] vset_to_mv(input logic [7:0] code);
        logic [15:0] off;
        logic [15:0] mv;
        off = 16'h0000;
        mv  = 16'h0000;
        if (code >= bkreg_pkg::VSET_R3_LO)
        begin
            off = {8'h00, code - bkreg_pkg::VSET_R3_LO};
            mv  = 16'(bkreg_pkg::MV_R3_BASE + off * bkreg_pkg::MV_STEP_R3);
        end
        else if (code >= bkreg_pkg::VSET_R2_LO)
        begin
            off = {8'h00, code - bkreg_pkg::VSET_R2_LO};
            mv  = 16'(bkreg_pkg::MV_R2_BASE + off * bkreg_pkg::MV_STEP_R2);
        end
        else if (code >= bkreg_pkg::VSET_R1_LO)
        begin
            off = {8'h00, code - bkreg_pkg::VSET_R1_LO};
            mv  = 16'(bkreg_pkg::MV_R1_BASE + off * bkreg_pkg::MV_STEP_R1);
        end
        // reserved codes give zero and a cleared valid flag
        return {(code >= bkreg_pkg::VSET_R1_LO), mv};
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] a_ls_q;
    logic [7:0] b_me_q;
    logic [7:0] b_ls_q;
    logic [7:0] a_v_q;
    logic [7:0] b_v_q;
    logic [bkreg_pkg::SYNC_STAGES-1:0] pin_sync_q;
    logic pin_q;

    wire sel_a_ls = i_addr == bkreg_pkg::ADDR_A_LIMIT_SLEW;
    wire sel_b_me = i_addr == bkreg_pkg::ADDR_B_MODE_ENABLE;
    wire sel_b_ls = i_addr == bkreg_pkg::ADDR_B_LIMIT_SLEW;
    wire sel_a_v  = i_addr == bkreg_pkg::ADDR_A_VOLTAGE;
    wire sel_b_v  = i_addr == bkreg_pkg::ADDR_B_VOLTAGE;

    // reserved bits are stored and read back, as the bank is all read/write
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            a_ls_q <= bkreg_pkg::RST_LIMIT_SLEW;
            b_me_q <= bkreg_pkg::RST_MODE_ENABLE;
            b_ls_q <= bkreg_pkg::RST_LIMIT_SLEW;
            a_v_q  <= bkreg_pkg::RST_A_VOLTAGE;
            b_v_q  <= bkreg_pkg::RST_B_VOLTAGE;
        end
        else if (i_wr_en)
        begin
            // no enable interlock: limit updates land immediately
            if (sel_a_ls) a_ls_q <= i_wdata;
            if (sel_b_me) b_me_q <= i_wdata;
            if (sel_b_ls) b_ls_q <= i_wdata;
            if (sel_a_v)  a_v_q  <= i_wdata;
            if (sel_b_v)  b_v_q  <= i_wdata;
        end
    end

    // ---------------------------------------------------------------
    // enable pin synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_sync_q <= '0;
            pin_q      <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], i_en_pin};
            if (pin_sync_q[2] == pin_sync_q[1])
                pin_q <= pin_sync_q[2];
        end
    end

    // ---------------------------------------------------------------
    // read path and decoded controls
    // ---------------------------------------------------------------
    assign o_addr_hit = sel_a_ls | sel_b_me | sel_b_ls | sel_a_v | sel_b_v;
    assign o_rdata = sel_a_ls ? a_ls_q : sel_b_me ? b_me_q : sel_b_ls ? b_ls_q :
                     sel_a_v ? a_v_q : sel_b_v ? b_v_q : 8'h00;

    // regulator a first control register lies outside this bank, so it runs on defaults
    assign o_a_run        = pin_q;
    assign o_a_pwm_forced = 1'b1;
    assign o_a_discharge  = ~o_a_run;
    wire b_on = b_me_q[bkreg_pkg::BIT_ON];
    assign o_b_run = b_me_q[bkreg_pkg::BIT_PIN] ? (b_on & pin_q) : b_on;
    assign o_b_pwm_forced = b_me_q[bkreg_pkg::BIT_FPWM];
    assign o_b_discharge  = b_me_q[bkreg_pkg::BIT_DIS] & ~o_b_run;

    assign o_a_current_limit = a_ls_q[bkreg_pkg::LIM_MSB:bkreg_pkg::LIM_LSB];
    assign o_b_current_limit = b_ls_q[bkreg_pkg::LIM_MSB:bkreg_pkg::LIM_LSB];
    assign o_a_limit_valid   = o_a_current_limit <= bkreg_pkg::LIM_MAX_CODE;
    assign o_b_limit_valid   = o_b_current_limit <= bkreg_pkg::LIM_MAX_CODE;
    assign o_a_ramp_rate     = a_ls_q[bkreg_pkg::RAMP_MSB:bkreg_pkg::RAMP_LSB];
    assign o_b_ramp_rate     = b_ls_q[bkreg_pkg::RAMP_MSB:bkreg_pkg::RAMP_LSB];

    wire [16:0] a_mv = vset_to_mv(a_v_q);
    wire [16:0] b_mv = vset_to_mv(b_v_q);
    assign o_a_millivolts    = a_mv[15:0];
    assign o_b_millivolts    = b_mv[15:0];
    assign o_a_voltage_valid = a_mv[16];
    assign o_b_voltage_valid = b_mv[16];

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_write_limit;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_wr_en && sel_a_ls) |=> (o_a_current_limit == $past(i_wdata[5:3]));
    endproperty
    a_write_limit: assert property (p_write_limit) else $error("limit write lost");

    property p_limit_valid;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_wr_en && sel_b_ls) |=> (o_b_limit_valid == ($past(i_wdata[5:4]) != 2'h3));
    endproperty
    a_limit_valid: assert property (p_limit_valid) else $error("limit valid wrong");

    property p_ramp;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_wr_en && sel_b_ls) |=> (o_b_ramp_rate == $past(i_wdata[2:0]));
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp write lost");

    property p_fpwm;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_wr_en && sel_b_me) |=> (o_b_pwm_forced == $past(i_wdata[3]));
    endproperty
    a_fpwm: assert property (p_fpwm) else $error("mode bit wrong");

    property p_discharge;
        @(posedge i_clk) disable iff (!i_rstn)
        (b_me_q[bkreg_pkg::BIT_DIS] && !b_me_q[bkreg_pkg::BIT_ON]) |-> (o_b_discharge && !o_b_run);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge missing when off");

    property p_run_off;
        @(posedge i_clk) disable iff (!i_rstn)
        !b_me_q[0] |-> !o_b_run;
    endproperty
    a_run_off: assert property (p_run_off) else $error("runs while disabled");

    property p_pin_gate;
        @(posedge i_clk) disable iff (!i_rstn)
        (b_me_q[1] && b_me_q[0]) |-> (o_b_run == pin_q);
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin gating wrong");

    property p_no_pin;
        @(posedge i_clk) disable iff (!i_rstn)
        (!b_me_q[1] && b_me_q[0]) |-> o_b_run;
    endproperty
    a_no_pin: assert property (p_no_pin) else $error("bit alone ignored");

    property p_vmid;
        @(posedge i_clk) disable iff (!i_rstn)
        (a_v_q == 8'h9D) |-> (o_a_millivolts == 16'h0578);
    endproperty
    a_vmid: assert property (p_vmid) else $error("range two end wrong");

    property p_vtop;
        @(posedge i_clk) disable iff (!i_rstn)
        (b_v_q == 8'hFF) |-> (o_b_millivolts == 16'h0D20);
    endproperty
    a_vtop: assert property (p_vtop) else $error("range three end wrong");

    property p_vlow;
        @(posedge i_clk) disable iff (!i_rstn)
        (a_v_q == 8'h17) |-> (o_a_millivolts == 16'h02DA);
    endproperty
    a_vlow: assert property (p_vlow) else $error("range one end wrong");

    property p_vres;
        @(posedge i_clk) disable iff (!i_rstn)
        (b_v_q < 8'h14) |-> !o_b_voltage_valid;
    endproperty
    a_vres: assert property (p_vres) else $error("reserved code valid");

    c_pin_run: cover property (@(posedge i_clk) disable iff (!i_rstn) o_b_run && b_me_q[1]);
    c_dis: cover property (@(posedge i_clk) disable iff (!i_rstn) o_b_discharge);
    c_vr3: cover property (@(posedge i_clk) disable iff (!i_rstn) a_v_q >= 8'h9E);
endmodule // bkreg_bank
`default_nettype wire

// ==== rtl/bkreg_pkg.sv ====
// constants for the buck regulator control register bank
package bkreg_pkg;
    localparam logic [7:0] ADDR_A_LIMIT_SLEW  = 8'h03;
    localparam logic [7:0] ADDR_B_MODE_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_B_LIMIT_SLEW  = 8'h05;
    localparam logic [7:0] ADDR_A_VOLTAGE     = 8'h06;
    localparam logic [7:0] ADDR_B_VOLTAGE     = 8'h07;
    localparam logic [7:0] RST_LIMIT_SLEW     = 8'h2C;
    localparam logic [7:0] RST_MODE_ENABLE    = 8'h0F;
    localparam logic [7:0] RST_A_VOLTAGE      = 8'h80;
    localparam logic [7:0] RST_B_VOLTAGE      = 8'hFC;
    localparam int LIM_MSB  = 5;
    localparam int LIM_LSB  = 3;
    localparam int RAMP_MSB = 2;
    localparam int RAMP_LSB = 0;
    localparam int BIT_FPWM = 3;
    localparam int BIT_DIS  = 2;
    localparam int BIT_PIN  = 1;
    localparam int BIT_ON   = 0;
    localparam logic [2:0] LIM_MAX_CODE  = 3'h5;
    localparam logic [2:0] RAMP_MIN_CODE = 3'h2;
    localparam logic [7:0] VSET_R1_LO    = 8'h14;
    localparam logic [7:0] VSET_R2_LO    = 8'h18;
    localparam logic [7:0] VSET_R3_LO    = 8'h9E;
    localparam logic [15:0] MV_R1_BASE   = 16'h02BC;
    localparam logic [15:0] MV_R2_BASE   = 16'h02DF;
    localparam logic [15:0] MV_R3_BASE   = 16'h058C;
    localparam logic [15:0] MV_STEP_R1   = 16'h000A;
    localparam logic [15:0] MV_STEP_R2   = 16'h0005;
    localparam logic [15:0] MV_STEP_R3   = 16'h0014;
    localparam int SYNC_STAGES = 3;
endpackage
